// file: fcr_top.sv
// flash configuration register with serial command link and ahb-lite register access
//
// Overview of operation
// - configuration register is readable; bit 0 is reserved and reads zero.
// - bit 1 quad pin select; one disables write-protect and reset/pause pins.
// - quad pin select high turns data lines 2 and 3 into data pins.
// - single-line quad commands are invalid unless quad pin select is set.
// - in four-bit command protocol quad pin select does not change pins.
// - quad pin select clears on power-up, hardware reset and software reset; here the set bit disables the reset pin, so hardware reset never clears it.
// - bit 2 lock flag sets when the lock-protection command executes.
// - while the lock flag is set, protect level bits cannot change.
// - lock flag clears only by hardware reset or power cycle.
// - bit 3 id-area lock sets on id lockout and clears only on power-up.
// - bit 4 sets on suspend during erase, clears on a resume that finds bit 5 already clear.
// - bit 5 sets on suspend during program, clears on resume.
// - bit 6 nonvolatile: one selects reset pin, zero selects pause pin.
// - nonvolatile bit write runs self-timed with busy set until done.
// - bit 7: hardware protection only when protect pin low and bit set.
// - hardware protection blocks only lockdown and configuration writes.
// - nonvolatile bits keep last written value; factory default zero. Here nrst also reloads them with zero.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fcr_defines.svh"
module fcr_top #(
  parameter int CFG_WRITE_NS = `FCR_CFG_WRITE_NS
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire fcr_pkg::fcr_word_t hwdata,
  input  wire logic              hready,
  output fcr_pkg::fcr_word_t     hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              link_cs_n,
  input  wire logic              link_sclk,
  input  wire logic              link_si,
  input  wire logic              data_line_2,
  input  wire logic              data_line_3,
  input  wire logic              erase_active,
  input  wire logic              program_active,
  output logic                   data_line_2_is_data,
  output logic                   data_line_3_is_data,
  output logic                   hw_write_protect,
  output logic                   hw_reset_pin_active,
  output logic                   pause_pin_active,
  output logic                   paused,
  output logic                   irq
);
  import fcr_pkg::*;

  localparam int NV_CYCLES_RAW = CFG_WRITE_NS / `FCR_CLK_NS;
  localparam int NV_CYCLES     = (NV_CYCLES_RAW < 1) ? 1 : NV_CYCLES_RAW;

  // pin side
  logic [4:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       si_s;
  logic       wp_n_s;
  logic       rp_n_s;
  logic       sclk_q;
  logic       cs_n_q;
  logic       rp_n_q;

  // idle levels: select high, link clock low, serial input low, data lines high; matches the edge detectors' reset
  fcr_sync #(.W(5), .INIT(5'h13)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   ({link_cs_n, link_sclk, link_si, data_line_2, data_line_3}),
    .dout  (pins_s)
  );
  assign {cs_n_s, sclk_s, si_s, wp_n_s, rp_n_s} = pins_s;

  // register state
  logic       qps_r;
  logic       vlp_r;
  logic       idl_r;
  logic       ers_r;
  logic       pgs_r;
  logic       rsp_r;
  logic       ppe_r;
  logic       rsp_pend_r;
  logic       ppe_pend_r;
  logic       wel_r;
  logic [1:0] bp_r;
  logic       bpl_r;
  logic       quad_proto_r;
  logic       rsten_r;
  logic [`FCR_IRQ_W-1:0] irq_stat_r;
  logic [`FCR_IRQ_W-1:0] irq_mask_r;

  // link receiver
  fcr_byte_t  sh_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  fcr_byte_t  op_r;
  fcr_byte_t  d1_r;
  fcr_byte_t  d2_r;
  logic       sclk_rise;
  logic       frame_end;
  logic       byte_done;

  // pin function, the reset and pause pin sits on data line 3
  assign data_line_2_is_data = quad_proto_r | qps_r;
  assign data_line_3_is_data = quad_proto_r | qps_r;
  assign hw_reset_pin_active = ~data_line_3_is_data & rsp_r;
  assign pause_pin_active    = ~data_line_3_is_data & ~rsp_r;
  assign paused              = pause_pin_active & ~rp_n_s;
  logic  wp_pin_low;
  assign wp_pin_low          = ~data_line_2_is_data & ~wp_n_s;
  assign hw_write_protect    = wp_pin_low & ppe_r;

  logic hw_rst;
  assign hw_rst = hw_reset_pin_active & ~rp_n_s & rp_n_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      rp_n_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      rp_n_q <= rp_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s & ~paused;
  assign frame_end = cs_n_s & ~cs_n_q;
  assign byte_done = sclk_rise & (bit_cnt_r == 3'h7);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_r       <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 2'h0;
      op_r       <= 8'h00;
      d1_r       <= 8'h00;
      d2_r       <= 8'h00;
    end
    else if (cs_n_s)
    begin
      bit_cnt_r  <= 3'h0;
      if (!frame_end)
        byte_cnt_r <= 2'h0;
    end
    else if (sclk_rise)
    begin
      sh_r      <= {sh_r[6:0], si_s};
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done)
      begin
        unique case (byte_cnt_r)
          2'h0: op_r <= {sh_r[6:0], si_s};
          2'h1: d1_r <= {sh_r[6:0], si_s};
          2'h2: d2_r <= {sh_r[6:0], si_s};
          2'h3: d2_r <= d2_r;
        endcase
        if (byte_cnt_r != 2'h3)
          byte_cnt_r <= byte_cnt_r + 2'h1;
      end
    end
  end

  // commands execute when chip select rises
  function automatic logic is_op(input fcr_byte_t op, input fcr_byte_t code, input logic [1:0] n, input logic end_p);
    is_op = end_p && (op == code) && (n != 2'h0);
  endfunction

  logic cmd_wren;
  logic cmd_wrsr;
  logic cmd_quad;
  logic cmd_qenter;
  logic cmd_qexit;
  logic cmd_rsten;
  logic cmd_rst;
  logic cmd_susp;
  logic cmd_resume;
  logic cmd_lock;
  logic cmd_idlock;
  logic sw_rst;
  assign cmd_wren   = is_op(op_r, `FCR_OP_WREN, byte_cnt_r, frame_end);
  assign cmd_wrsr   = is_op(op_r, `FCR_OP_WRSR, byte_cnt_r, frame_end) & wel_r;
  assign cmd_quad   = frame_end && (byte_cnt_r != 2'h0) &&
                      (op_r == `FCR_OP_QOUT || op_r == `FCR_OP_QIO ||
                       op_r == `FCR_OP_QPP || op_r == `FCR_OP_WRAP);
  assign cmd_qenter = is_op(op_r, `FCR_OP_QENTER, byte_cnt_r, frame_end);
  assign cmd_qexit  = is_op(op_r, `FCR_OP_QEXIT, byte_cnt_r, frame_end);
  assign cmd_rsten  = is_op(op_r, `FCR_OP_RSTEN, byte_cnt_r, frame_end);
  assign cmd_rst    = is_op(op_r, `FCR_OP_RST, byte_cnt_r, frame_end);
  assign cmd_susp   = is_op(op_r, `FCR_OP_SUSPEND, byte_cnt_r, frame_end);
  assign cmd_resume = is_op(op_r, `FCR_OP_RESUME, byte_cnt_r, frame_end);
  assign cmd_lock   = is_op(op_r, `FCR_OP_LOCKPROT, byte_cnt_r, frame_end) & wel_r;
  assign cmd_idlock = is_op(op_r, `FCR_OP_IDLOCK, byte_cnt_r, frame_end) & wel_r;
  assign sw_rst     = cmd_rst & rsten_r;

  logic quad_invalid;
  assign quad_invalid = cmd_quad & ~quad_proto_r & ~qps_r;

  // ahb-lite slave, zero wait states
  logic       ap_valid;
  logic       dp_wr_r;
  logic [7:0] dp_addr_r;
  assign ap_valid  = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end
    else
    begin
      dp_wr_r   <= ap_valid & hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  logic nv_busy;
  logic nv_done;
  logic [7:0] cfg_rd;
  logic [7:0] stat_rd;
  assign cfg_rd  = {ppe_r, rsp_r, pgs_r, ers_r, idl_r, vlp_r, qps_r, 1'b0};
  assign stat_rd = {bpl_r, 3'h0, bp_r, wel_r, nv_busy};

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hrdata <= 32'h0;
    else if (ap_valid && !hwrite)
    begin
      unique case (haddr[7:0])
        `FCR_OFF_CFG:      hrdata <= {24'h0, cfg_rd};
        `FCR_OFF_STAT:     hrdata <= {24'h0, stat_rd};
        `FCR_OFF_IRQ_STAT: hrdata <= {28'h0, irq_stat_r};
        `FCR_OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask_r};
        default:           hrdata <= 32'h0;
      endcase
    end
  end

  // unified write requests from link and bus
  logic       cfg_wr;
  logic [7:0] cfg_wd;
  logic       st_wr;
  logic [7:0] st_wd;
  assign cfg_wr = (dp_wr_r && dp_addr_r == `FCR_OFF_CFG) || (cmd_wrsr && byte_cnt_r == 2'h3);
  assign cfg_wd = cmd_wrsr ? d2_r : hwdata[7:0];
  assign st_wr  = (dp_wr_r && dp_addr_r == `FCR_OFF_STAT) || cmd_wrsr;
  assign st_wd  = cmd_wrsr ? d1_r : hwdata[7:0];

  logic cfg_ok;
  logic cfg_reject;
  logic nv_start;
  assign cfg_ok     = cfg_wr & ~hw_write_protect & ~nv_busy;
  assign cfg_reject = cfg_wr & ~cfg_ok;
  assign nv_start   = cfg_ok && ((cfg_wd[`FCR_CFG_RSP] != rsp_r) ||
                                 (cfg_wd[`FCR_CFG_PPE] != ppe_r));

  fcr_nv_timer #(.CYCLES(NV_CYCLES)) u_nv (
    .clock (clock),
    .nrst  (nrst),
    .start (nv_start),
    .busy  (nv_busy),
    .done  (nv_done)
  );

  // quad pin select; read-only bits ignore written data
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      qps_r <= 1'b0;
    else if (hw_rst || sw_rst)
      qps_r <= 1'b0;
    else if (cfg_ok)
      qps_r <= cfg_wd[`FCR_CFG_QPS];
  end

  // nonvolatile bits commit when the self-timed write completes
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_r      <= `FCR_NV_RESET;
      ppe_r      <= `FCR_NV_RESET;
      rsp_pend_r <= `FCR_NV_RESET;
      ppe_pend_r <= `FCR_NV_RESET;
    end
    else
    begin
      if (nv_start)
      begin
        rsp_pend_r <= cfg_wd[`FCR_CFG_RSP];
        ppe_pend_r <= cfg_wd[`FCR_CFG_PPE];
      end
      if (nv_done)
      begin
        rsp_r <= rsp_pend_r;
        ppe_r <= ppe_pend_r;
      end
    end
  end

  // volatile lock and id lock
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      vlp_r <= 1'b0;
      idl_r <= 1'b0;
    end
    else
    begin
      if (hw_rst)
        vlp_r <= 1'b0;
      else if (cmd_lock)
        vlp_r <= 1'b1;
      if (cmd_idlock)
        idl_r <= 1'b1;
    end
  end

  // suspend flags
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ers_r <= 1'b0;
      pgs_r <= 1'b0;
    end
    else if (hw_rst || sw_rst)
    begin
      ers_r <= 1'b0;
      pgs_r <= 1'b0;
    end
    else if (cmd_susp)
    begin
      if (erase_active)
        ers_r <= 1'b1;
      if (program_active)
        pgs_r <= 1'b1;
    end
    else if (cmd_resume)
    begin
      if (pgs_r)
        pgs_r <= 1'b0;
      else
        ers_r <= 1'b0;
    end
  end

  // status: write enable, protect level, lockdown
  logic bp_ok;
  logic bpl_ok;
  assign bp_ok  = ~vlp_r & ~(bpl_r & wp_pin_low);
  assign bpl_ok = ~hw_write_protect & ~(bpl_r & wp_pin_low);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wel_r <= 1'b0;
      bp_r  <= `FCR_BP_RESET;
      bpl_r <= 1'b0;
    end
    else if (hw_rst)
    begin
      wel_r <= 1'b0;
      bp_r  <= `FCR_BP_RESET;
      bpl_r <= 1'b0;
    end
    else
    begin
      if (sw_rst || cmd_wrsr || cmd_lock || cmd_idlock || cmd_susp)
        wel_r <= 1'b0;
      else if (cmd_wren)
        wel_r <= 1'b1;
      if (st_wr && bp_ok && !nv_busy)
        bp_r <= st_wd[`FCR_ST_BPH:`FCR_ST_BPL];
      if (st_wr && bpl_ok && !nv_busy)
        bpl_r <= st_wd[`FCR_ST_LOCKDN];
    end
  end

  // protocol mode and reset arming
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      quad_proto_r <= 1'b0;
      rsten_r      <= 1'b0;
    end
    else
    begin
      if (hw_rst || sw_rst || cmd_qexit)
        quad_proto_r <= 1'b0;
      else if (cmd_qenter)
        quad_proto_r <= 1'b1;
      if (frame_end && byte_cnt_r != 2'h0)
        rsten_r <= cmd_rsten;
    end
  end

  // interrupts: set wins over write-one-to-clear
  logic [`FCR_IRQ_W-1:0] irq_set;
  logic [`FCR_IRQ_W-1:0] irq_clr;
  assign irq_set = {cmd_susp, cfg_reject, quad_invalid, nv_done};
  assign irq_clr = (dp_wr_r && dp_addr_r == `FCR_OFF_IRQ_STAT) ? hwdata[`FCR_IRQ_W-1:0] : '0;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (dp_wr_r && dp_addr_r == `FCR_OFF_IRQ_MASK)
        irq_mask_r <= hwdata[`FCR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);
endmodule

// file: fcr_defines.svh
// offsets, field positions, reset values, opcodes and timing of the flash configuration block
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH
`define FCR_OFF_CFG      8'h00
`define FCR_OFF_STAT     8'h04
`define FCR_OFF_IRQ_STAT 8'h08
`define FCR_OFF_IRQ_MASK 8'h0c
`define FCR_CFG_QPS      1
`define FCR_CFG_VLP      2
`define FCR_CFG_IDL      3
`define FCR_CFG_ERS      4
`define FCR_CFG_PGS      5
`define FCR_CFG_RSP      6
`define FCR_CFG_PPE      7
`define FCR_ST_BUSY      0
`define FCR_ST_WEL       1
`define FCR_ST_BPL       2
`define FCR_ST_BPH       3
`define FCR_ST_LOCKDN    7
`define FCR_IRQ_NVDONE   0
`define FCR_IRQ_INVALID  1
`define FCR_IRQ_REJECT   2
`define FCR_IRQ_SUSPEND  3
`define FCR_IRQ_W        4
`define FCR_NV_RESET     1'b0
`define FCR_BP_RESET     2'b11
`define FCR_OP_WREN      8'h06
`define FCR_OP_WRSR      8'h01
`define FCR_OP_QOUT      8'h6b
`define FCR_OP_QIO       8'heb
`define FCR_OP_QPP       8'h32
`define FCR_OP_WRAP      8'hec
`define FCR_OP_QENTER    8'h38
`define FCR_OP_QEXIT     8'hff
`define FCR_OP_RSTEN     8'h66
`define FCR_OP_RST       8'h99
`define FCR_OP_SUSPEND   8'hb0
`define FCR_OP_RESUME    8'h30
`define FCR_OP_LOCKPROT  8'h8d
`define FCR_OP_IDLOCK    8'h85
`define FCR_CLK_NS       10
`define FCR_CFG_WRITE_NS 1000
`endif

// file: fcr_pkg.sv
// types shared by the flash configuration block
package fcr_pkg;
  typedef logic [31:0] fcr_word_t;
  typedef logic [7:0]  fcr_byte_t;
  typedef enum logic [0:0] {FCR_NV_IDLE = 1'b0, FCR_NV_BUSY = 1'b1} fcr_nv_e;
endpackage

// file: fcr_sync.sv
// three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module fcr_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_r[i] <= INIT[i];
          s2_r[i] <= INIT[i];
          s3_r[i] <= INIT[i];
          dout[i] <= INIT[i];
        end
        else
        begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

// file: fcr_nv_timer.sv
// self-timed nonvolatile write: busy from start until the count expires
`timescale 1ns/1ps
module fcr_nv_timer #(
  parameter int CYCLES = 100
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import fcr_pkg::*;
  fcr_nv_e      state_r;
  logic [31:0]  cnt_r;

  assign busy = (state_r == FCR_NV_BUSY);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= FCR_NV_IDLE;
      cnt_r   <= 32'h0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state_r)
        FCR_NV_IDLE:
        begin
          if (start)
          begin
            state_r <= FCR_NV_BUSY;
            cnt_r   <= 32'(CYCLES - 1);
          end
        end
        FCR_NV_BUSY:
        begin
          if (cnt_r == 32'h0)
          begin
            state_r <= FCR_NV_IDLE;
            done    <= 1'b1;
          end
          else
            cnt_r <= cnt_r - 32'h1;
        end
      endcase
    end
  end
endmodule

// file: fcr_host_model.sv
// host-side serial link driver facing the flash configuration block
`timescale 1ns/1ps
module fcr_host_model (
  input  wire logic clock,
  output logic      link_cs_n,
  output logic      link_sclk,
  output logic      link_si
);
  initial
  begin
    link_cs_n = 1'b1;
    link_sclk = 1'b0;
    link_si   = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // eight clocks each half period gives the 160 ns link clock; sclk rests low between frames
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    logic [23:0] bits = {b0, b1, b2};
    link_cs_n <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < 8 * n; i++)
    begin
      link_si <= bits[23 - i];
      wait_clk(8);
      link_sclk <= 1'b1;
      wait_clk(8);
      link_sclk <= 1'b0;
    end
    wait_clk(8);
    link_cs_n <= 1'b1;
    // released line must not keep showing the last bit
    link_si   <= ~link_si;
    wait_clk(16);
  endtask
endmodule

// file: fcr_top_chk.sv
// concurrent checks on the pin-function and bus answer ports of the flash configuration block
`timescale 1ns/1ps
module fcr_top_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic data_line_2,
  input wire logic data_line_3,
  input wire logic data_line_2_is_data,
  input wire logic data_line_3_is_data,
  input wire logic hw_write_protect,
  input wire logic hw_reset_pin_active,
  input wire logic pause_pin_active,
  input wire logic paused
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // six samples outlast the three-stage pin synchroniser
  sequence line2_high_settled;
    data_line_2 [*6];
  endsequence
  sequence line3_high_settled;
    data_line_3 [*6];
  endsequence

  bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  quad_pins_a: assert property (data_line_2_is_data == data_line_3_is_data)
    else $error("data lines 2 and 3 disagree on role");
  data_no_ctrl_a: assert property (data_line_3_is_data |-> !hw_reset_pin_active && !pause_pin_active)
    else $error("control pin active while line is data");
  one_pin_mode_a: assert property (!data_line_3_is_data |-> hw_reset_pin_active != pause_pin_active)
    else $error("line 3 control role not exactly one");
  wp_data_off_a: assert property (data_line_2_is_data |-> !hw_write_protect)
    else $error("write protect active while line 2 is data");
  wp_pin_high_a: assert property (line2_high_settled |-> !hw_write_protect)
    else $error("write protect with protect pin high");
  pause_pin_a: assert property (paused |-> pause_pin_active)
    else $error("paused without pause role");
  pause_release_a: assert property (line3_high_settled |-> !paused)
    else $error("paused with pin high");
endmodule

bind fcr_top fcr_top_chk i_chk (
  .clock, .nrst, .hreadyout, .hresp, .data_line_2, .data_line_3, .data_line_2_is_data,
  .data_line_3_is_data, .hw_write_protect, .hw_reset_pin_active, .pause_pin_active, .paused
);

// file: fcr_top_tb_top.sv
// self-checking testbench of the flash configuration block
`timescale 1ns/1ps
`include "fcr_defines.svh"
`define CHK(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end
module fcr_top_tb_top;
  import fcr_pkg::*;
  localparam int CFG_NS = 200;
  localparam int LIMIT  = 40000;
  logic        clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, erase_active = 1'b0, program_active = 1'b0;
  logic        data_line_2 = 1'b1, data_line_3 = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  fcr_word_t   hwdata = '0;
  fcr_word_t   hrdata;
  logic        hreadyout, hresp, link_cs_n, link_sclk, link_si, data_line_2_is_data, data_line_3_is_data;
  logic        hw_write_protect, hw_reset_pin_active, pause_pin_active, paused, irq;
  int          mismatches = 0, check_count = 0, cycles = 0;

  fcr_top #(.CFG_WRITE_NS(CFG_NS)) i_dut (
    .clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .link_cs_n, .link_sclk, .link_si, .data_line_2, .data_line_3, .erase_active,
    .program_active, .data_line_2_is_data, .data_line_3_is_data, .hw_write_protect, .hw_reset_pin_active,
    .pause_pin_active, .paused, .irq
  );
  fcr_host_model i_host (.clock, .link_cs_n, .link_sclk, .link_si);

  always #5 clock = ~clock;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // no cycle count assumed; only the bench timeout ends a stuck wait
  task automatic wait_rdy();
    do
      @(posedge clock);
    while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input fcr_word_t wd, output fcr_word_t rdat);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input fcr_word_t d);
    fcr_word_t x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input fcr_word_t e, input string m);
    fcr_word_t x;
    bus(1'b0, a, '0, x);
    `CHK(x, e, m)
  endtask

  task automatic cmd(input logic [7:0] op);
    i_host.send(op, 8'h00, 8'h00, 1);
  endtask

  task automatic sreset();
    cmd(`FCR_OP_RSTEN);
    cmd(`FCR_OP_RST);
  endtask

  task automatic poll_busy();
    fcr_word_t x;
    int n = 0;
    do
    begin
      bus(1'b0, `FCR_OFF_STAT, '0, x);
      n++;
    end
    while (x[`FCR_ST_BUSY] !== 1'b0 && n < 100);
    `CHK(x[`FCR_ST_BUSY], 1'b0, "busy never cleared")
  endtask

  task automatic t_reset();
    rd_chk(`FCR_OFF_CFG, 32'h00000000, "cfg reset value");
    rd_chk(`FCR_OFF_STAT, 32'h0000000c, "status reset value");
    rd_chk(8'h10, 32'h00000000, "unmapped read");
    `CHK(pause_pin_active, 1'b1, "pause role after reset")
    `CHK(data_line_2_is_data, 1'b0, "line 2 data after reset")
    $display("test reset done");
  endtask

  task automatic t_quad();
    logic [7:0] ops [4] = '{`FCR_OP_QOUT, `FCR_OP_QIO, `FCR_OP_QPP, `FCR_OP_WRAP};
    wr(`FCR_OFF_IRQ_MASK, 32'h0000000f);
    foreach (ops[i])
    begin
      cmd(ops[i]);
      rd_chk(`FCR_OFF_IRQ_STAT, 32'h00000002, "quad command not refused");
      `CHK(irq, 1'b1, "irq low on refusal")
      wr(`FCR_OFF_IRQ_STAT, 32'h00000002);
    end
    wait_clk(1);
    `CHK(irq, 1'b0, "irq stuck after clear")
    // host selects quad pins before the next quad command
    wr(`FCR_OFF_CFG, 32'h0000003f);
    rd_chk(`FCR_OFF_CFG, 32'h00000002, "read-only bits taken");
    `CHK(data_line_3_is_data, 1'b1, "line 3 not data");
    `CHK(pause_pin_active, 1'b0, "pause role with quad select")
    cmd(`FCR_OP_QOUT);
    rd_chk(`FCR_OFF_IRQ_STAT, 32'h00000000, "quad command refused");
    sreset();
    rd_chk(`FCR_OFF_CFG, 32'h00000000, "quad select kept by soft reset");
    cmd(`FCR_OP_QENTER);
    `CHK(data_line_2_is_data, 1'b1, "quad protocol pins not data")
    cmd(`FCR_OP_QEXIT);
    `CHK(data_line_2_is_data, 1'b0, "quad protocol not left")
    cmd(`FCR_OP_QENTER);
    nrst <= 1'b0;
    wait_clk(2);
    nrst <= 1'b1;
    wait_clk(1);
    `CHK(data_line_3_is_data, 1'b0, "data role kept through reset")
    $display("test quad done");
  endtask

  task automatic t_suspend();
    erase_active <= 1'b1;
    cmd(`FCR_OP_SUSPEND);
    erase_active <= 1'b0;
    rd_chk(`FCR_OFF_CFG, 32'h00000010, "erase suspend flag");
    rd_chk(`FCR_OFF_IRQ_STAT, 32'h00000008, "suspend event");
    program_active <= 1'b1;
    cmd(`FCR_OP_SUSPEND);
    program_active <= 1'b0;
    rd_chk(`FCR_OFF_CFG, 32'h00000030, "program suspend flag");
    cmd(`FCR_OP_RESUME);
    rd_chk(`FCR_OFF_CFG, 32'h00000010, "program resume");
    cmd(`FCR_OP_RESUME);
    rd_chk(`FCR_OFF_CFG, 32'h00000000, "erase resume");
    $display("test suspend done");
  endtask

  task automatic t_lock();
    cmd(`FCR_OP_WREN);
    cmd(`FCR_OP_LOCKPROT);
    rd_chk(`FCR_OFF_CFG, 32'h00000004, "lock flag");
    wr(`FCR_OFF_STAT, 32'h00000000);
    rd_chk(`FCR_OFF_STAT, 32'h0000000c, "level changed under lock");
    cmd(`FCR_OP_WREN);
    cmd(`FCR_OP_IDLOCK);
    rd_chk(`FCR_OFF_CFG, 32'h0000000c, "id lock flag");
    sreset();
    rd_chk(`FCR_OFF_CFG, 32'h0000000c, "soft reset cleared locks");
    $display("test lock done");
  endtask

  task automatic t_nv();
    wr(`FCR_OFF_CFG, 32'h000000c0);
    wait_clk(2);
    rd_chk(`FCR_OFF_STAT, 32'h0000000d, "busy not raised");
    rd_chk(`FCR_OFF_CFG, 32'h0000000c, "nonvolatile bits early");
    poll_busy();
    rd_chk(`FCR_OFF_CFG, 32'h000000cc, "nonvolatile write");
    rd_chk(`FCR_OFF_IRQ_STAT, 32'h00000009, "write done event");
    `CHK(hw_reset_pin_active, 1'b1, "reset role missing")
    data_line_3 <= 1'b0;
    wait_clk(10);
    data_line_3 <= 1'b1;
    wait_clk(10);
    rd_chk(`FCR_OFF_CFG, 32'h000000c8, "hardware reset result");
    data_line_2 <= 1'b0;
    wait_clk(10);
    `CHK(hw_write_protect, 1'b1, "protection off")
    wr(`FCR_OFF_CFG, 32'h00000000);
    rd_chk(`FCR_OFF_CFG, 32'h000000c8, "cfg written under protection");
    wr(`FCR_OFF_STAT, 32'h00000080);
    rd_chk(`FCR_OFF_STAT, 32'h00000000, "status under protection");
    data_line_2 <= 1'b1;
    wait_clk(10);
    `CHK(hw_write_protect, 1'b0, "protection with pin high")
    wr(`FCR_OFF_CFG, 32'h00000000);
    poll_busy();
    rd_chk(`FCR_OFF_CFG, 32'h00000008, "nonvolatile clear");
    data_line_3 <= 1'b0;
    wait_clk(10);
    `CHK(paused, 1'b1, "pause pin ignored")
    data_line_3 <= 1'b1;
    wait_clk(10);
    cmd(`FCR_OP_WREN);
    i_host.send(`FCR_OP_WRSR, 8'h00, 8'h02, 3);
    rd_chk(`FCR_OFF_CFG, 32'h0000000a, "link config write");
    $display("test nonvolatile done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_quad();
    t_suspend();
    t_lock();
    t_nv();
    end_of_test();
  end
endmodule
